// ==== logic/sfh_consts.svh ====
// Constants of the serial flash front end: opcodes, status bit positions,
// power-up status value, erase spans and the read underrun filler byte.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef SFH_CONSTS_SVH
`define SFH_CONSTS_SVH

// Opcodes, shifted most significant bit first.
`define SFH_OP_READ 8'h03
`define SFH_OP_FAST_READ 8'h0b
`define SFH_OP_SECTOR_ERASE 8'h20
`define SFH_OP_BLOCK32_ERASE 8'h52
`define SFH_OP_BLOCK64_ERASE 8'hd8
`define SFH_OP_CHIP_ERASE_A 8'h60
`define SFH_OP_CHIP_ERASE_B 8'hc7
`define SFH_OP_BYTE_PROGRAM 8'h02
`define SFH_OP_STREAM_PROGRAM 8'had
`define SFH_OP_STATUS_READ 8'h05
`define SFH_OP_STATUS_ARM 8'h50
`define SFH_OP_STATUS_WRITE 8'h01
`define SFH_OP_WRITE_ARM 8'h06
`define SFH_OP_WRITE_DISARM 8'h04

// Status word bit positions.
`define SFH_BIT_BUSY 0
`define SFH_BIT_WRITE_LATCH 1
`define SFH_BIT_GUARD_LO 2
`define SFH_BIT_GUARD_HI 5
`define SFH_BIT_STREAM 6
`define SFH_BIT_LOCKDOWN 7

// Power-up values of the writable status fields.
`define SFH_GUARD_RESET 4'h7
`define SFH_LOCK_RESET 1'h0

// Erase spans in bytes; zero marks the whole array.
`define SFH_SECTOR_BYTES 17'h01000
`define SFH_BLOCK32_BYTES 17'h08000
`define SFH_BLOCK64_BYTES 17'h10000
`define SFH_CHIP_BYTES 17'h00000

// Filler byte sent when read data is not yet available.
`define SFH_UNDERRUN_BYTE 8'hff

`endif

// ==== logic/sfh_pkg.sv ====
// Types shared by the serial flash front end modules.
// Assumes the constants header is compiled alongside it.
package sfh_pkg;

  // Phase of the serial command sequence.
  typedef enum logic [2:0] {
    SFH_OPC = 3'b000,
    SFH_ADDR = 3'b001,
    SFH_DUMMY = 3'b010,
    SFH_DIN = 3'b011,
    SFH_DOUT = 3'b100,
    SFH_IGNORE = 3'b101
  } sfh_phase_t;

  // Whole state of the serial core.
  typedef struct packed {
    sfh_phase_t phase;
    logic held;
    logic sck_prev;
    logic sel_prev;
    logic [7:0] sh_in;
    logic [2:0] bitcnt;
    logic [1:0] nbyte;
    logic addr_ok;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic have_wdata;
    logic [7:0] wdata;
    logic [7:0] out_sh;
    logic out_act;
    logic sdo;
    logic sdo_oe;
    logic write_latch;
    logic [3:0] guard;
    logic guard_lockdown;
    logic op_strobe;
    logic [7:0] op_code;
    logic [23:0] op_addr;
    logic [16:0] erase_span;
    logic wr_strobe;
    logic [7:0] wr_byte;
  } sfh_core_t;

endpackage

// ==== logic/sfh_pin_sync.sv ====
// Three-stage synchroniser for a group of pins; a change is accepted once
// the second and third stages agree.
// Assumes every input is asynchronous to ref_clk.
`timescale 1ns/100ps
module sfh_pin_sync import sfh_pkg::*; #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Raw pins and filtered levels.
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_val
);

  // State held as one packed struct.
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } sfh_sync_t;

  sfh_sync_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, so a metastable bit never fans out.
  always_comb begin
    d = q;
    d.s1 = pin_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.val[i] = q.s3[i];
      end
    end
  end

  // Registers of the synchroniser.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= {INIT, INIT, INIT, INIT};
    end else begin
      q <= d;
    end
  end

  assign pin_val = q.val;

endmodule

// ==== logic/sfh_read_buf.sv ====
// Small FIFO for read data between the array side and the serial shifter.
// Assumes the drain side takes a word only while out_valid is high.
`timescale 1ns/100ps
module sfh_read_buf import sfh_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // State held as one packed struct.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
  } sfh_buf_t;

  sfh_buf_t q, d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full is registered so the ready seen by the source comes from a flop.
  always_comb begin
    d = q;
    push = in_valid && !q.full;
    pop = out_ready && (q.count != '0);
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr_ptr + 1'b1);
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(q.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      d.count = (AW + 1)'(q.count + 1'b1);
    end else if (pop && !push) begin
      d.count = (AW + 1)'(q.count - 1'b1);
    end
    d.full = (d.count == (AW + 1)'(DEPTH));
  end

  // Registers of the buffer.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = !q.full;
  assign out_valid = (q.count != '0);
  assign out_data = q.mem[q.rd_ptr];

endmodule

// ==== logic/sfh_flash_front.sv ====
// Serial front end of a flash memory: pin sampling, pause handling, command
// sequencing, the status word and its write protection.
// Assumes an array engine outside that runs program and erase operations,
// reports busy, streaming mode and completion, and supplies read data.
`timescale 1ns/100ps
`include "sfh_consts.svh"
module sfh_flash_front import sfh_pkg::*; #(
  parameter int READ_BUF_DEPTH = 2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Serial pins.
  input wire logic sel_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic pause_n,
  input wire logic wprot_n,
  // Array engine status.
  input wire logic busy_in,
  input wire logic streaming_program_flag,
  input wire logic ready_busy_en,
  input wire logic op_done,
  // Operation request to the array engine.
  output logic op_strobe,
  output logic [7:0] op_code,
  output logic [23:0] op_addr,
  output logic [16:0] erase_span,
  // Program data stream to the array engine.
  output logic wr_strobe,
  output logic [7:0] wr_byte,
  // Read data from the array engine.
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready,
  // Status word for observation.
  output logic [7:0] flash_state_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  logic [4:0] pins_s;
  logic sel_n_s;
  logic pause_n_s;
  logic wprot_n_s;
  logic sck_s;
  logic sdi_s;

  // Idle levels: deselected, not paused, unprotected, clock low.
  sfh_pin_sync #(
    .WIDTH(5),
    .INIT(5'h1c)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_raw({sel_n, pause_n, wprot_n, sck, sdi}),
    .pin_val(pins_s)
  );

  assign sel_n_s = pins_s[4];
  assign pause_n_s = pins_s[3];
  assign wprot_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer; the shifter drains it one byte per output byte.

  logic [7:0] buf_data;
  logic buf_valid;
  logic buf_pop;

  sfh_read_buf #(
    .WIDTH(8),
    .DEPTH(READ_BUF_DEPTH)
  ) u_rdbuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_data(rd_data),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core state.

  sfh_core_t q, d;
  logic sck_rise;
  logic sck_fall;
  logic sel_rise;
  logic [7:0] in_byte;
  logic [7:0] status_now;

  // Decodes opcodes that carry three address bytes.
  function automatic logic has_addr(input logic [7:0] op);
    case (op)
      `SFH_OP_READ, `SFH_OP_FAST_READ, `SFH_OP_SECTOR_ERASE, `SFH_OP_BLOCK32_ERASE,
      `SFH_OP_BLOCK64_ERASE, `SFH_OP_BYTE_PROGRAM, `SFH_OP_STREAM_PROGRAM: has_addr = 1'b1;
      default: has_addr = 1'b0;
    endcase
  endfunction

  // Erase span of an erase opcode; zero for the whole array.
  function automatic logic [16:0] span_of(input logic [7:0] op);
    case (op)
      `SFH_OP_SECTOR_ERASE: span_of = `SFH_SECTOR_BYTES;
      `SFH_OP_BLOCK32_ERASE: span_of = `SFH_BLOCK32_BYTES;
      `SFH_OP_BLOCK64_ERASE: span_of = `SFH_BLOCK64_BYTES;
      default: span_of = `SFH_CHIP_BYTES;
    endcase
  endfunction

  // Status word assembled from latched fields and engine inputs.
  always_comb begin
    status_now = 8'h00;
    status_now[`SFH_BIT_BUSY] = busy_in;
    status_now[`SFH_BIT_WRITE_LATCH] = q.write_latch;
    status_now[`SFH_BIT_GUARD_HI:`SFH_BIT_GUARD_LO] = q.guard;
    status_now[`SFH_BIT_STREAM] = streaming_program_flag;
    status_now[`SFH_BIT_LOCKDOWN] = q.guard_lockdown;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Edges are taken from the filtered clock level, so the
  // serial clock must stay well below a quarter of ref_clk.
  always_comb begin
    d = q;
    d.op_strobe = 1'b0;
    d.wr_strobe = 1'b0;
    buf_pop = 1'b0;
    sck_rise = sck_s && !q.sck_prev;
    sck_fall = !sck_s && q.sck_prev;
    sel_rise = sel_n_s && !q.sel_prev;
    in_byte = {q.sh_in[6:0], sdi_s};
    d.sck_prev = sck_s;
    d.sel_prev = sel_n_s;

    // While selected, pause state only changes with the clock low; when deselected it can
    // only be left by raising the pause pin.
    if (sel_n_s) begin
      d.held = q.held && !pause_n_s;
    end else if (!sck_s) begin
      d.held = !pause_n_s;
    end

    // Engine completion clears the latch; an arm command below overrides it.
    if (op_done) begin
      d.write_latch = 1'b0;
    end

    if (sel_n_s) begin
      // Deselect ends the command; a deselect while paused only resets.
      if (sel_rise && !q.held && q.bitcnt == 3'h0) begin
        case (q.opcode)
          `SFH_OP_WRITE_ARM, `SFH_OP_STATUS_ARM: begin
            d.write_latch = 1'b1;
          end
          `SFH_OP_WRITE_DISARM: begin
            d.write_latch = 1'b0;
          end
          `SFH_OP_STATUS_WRITE: begin
            if (q.have_wdata && q.write_latch) begin
              if (wprot_n_s || !q.guard_lockdown) begin
                d.guard = q.wdata[`SFH_BIT_GUARD_HI:`SFH_BIT_GUARD_LO];
                d.guard_lockdown = q.wdata[`SFH_BIT_LOCKDOWN];
              end
              d.write_latch = 1'b0;
            end
          end
          `SFH_OP_SECTOR_ERASE, `SFH_OP_BLOCK32_ERASE, `SFH_OP_BLOCK64_ERASE,
          `SFH_OP_BYTE_PROGRAM, `SFH_OP_STREAM_PROGRAM: begin
            if (q.addr_ok && q.write_latch) begin
              d.op_strobe = 1'b1;
              d.op_code = q.opcode;
              d.op_addr = q.addr;
              d.erase_span = span_of(q.opcode);
            end
          end
          `SFH_OP_CHIP_ERASE_A, `SFH_OP_CHIP_ERASE_B: begin
            // Whole-array erase is refused while any region is guarded.
            if (q.write_latch && q.guard == 4'h0) begin
              d.op_strobe = 1'b1;
              d.op_code = q.opcode;
              d.op_addr = 24'h000000;
              d.erase_span = `SFH_CHIP_BYTES;
            end
          end
          default: begin
          end
        endcase
      end
      // Serial logic returns to standby; the output may report ready/busy.
      d.phase = SFH_OPC;
      d.bitcnt = 3'h0;
      d.nbyte = 2'h0;
      d.addr_ok = 1'b0;
      d.have_wdata = 1'b0;
      d.opcode = 8'h00;
      d.out_act = 1'b0;
      d.sdo_oe = ready_busy_en && streaming_program_flag;
      d.sdo = !busy_in;
    end else if (q.held) begin
      // Paused: output released, clock and data levels disregarded. On leaving
      // the pause a read drives again the bit it showed before, because the
      // host may sample before any further falling edge comes.
      d.sdo_oe = !d.held && q.out_act;
    end else if (sck_rise) begin
      // Input bits are taken on the rising edge in either clock mode.
      d.sh_in = in_byte;
      d.bitcnt = 3'(q.bitcnt + 3'h1);
      if (q.bitcnt == 3'h7) begin
        case (q.phase)
          SFH_OPC: begin
            // While the engine is busy only status reads are honoured.
            if (busy_in && in_byte != `SFH_OP_STATUS_READ) begin
              d.phase = SFH_IGNORE;
            end else begin
              d.opcode = in_byte;
              if (has_addr(in_byte)) begin
                d.phase = SFH_ADDR;
              end else if (in_byte == `SFH_OP_STATUS_READ) begin
                d.phase = SFH_DOUT;
                d.out_sh = status_now;
                d.out_act = 1'b1;
              end else if (in_byte == `SFH_OP_STATUS_WRITE) begin
                d.phase = SFH_DIN;
              end else begin
                d.phase = SFH_IGNORE;
              end
            end
          end
          SFH_ADDR: begin
            d.addr = {q.addr[15:0], in_byte};
            d.nbyte = 2'(q.nbyte + 2'h1);
            if (q.nbyte == 2'h2) begin
              d.addr_ok = 1'b1;
              if (q.opcode == `SFH_OP_READ) begin
                d.phase = SFH_DOUT;
                d.out_act = 1'b1;
                buf_pop = buf_valid;
                d.out_sh = buf_valid ? buf_data : `SFH_UNDERRUN_BYTE;
              end else if (q.opcode == `SFH_OP_FAST_READ) begin
                d.phase = SFH_DUMMY;
              end else if (q.opcode == `SFH_OP_BYTE_PROGRAM || q.opcode == `SFH_OP_STREAM_PROGRAM) begin
                d.phase = SFH_DIN;
              end else begin
                d.phase = SFH_IGNORE;
              end
            end
          end
          SFH_DUMMY: begin
            d.phase = SFH_DOUT;
            d.out_act = 1'b1;
            buf_pop = buf_valid;
            d.out_sh = buf_valid ? buf_data : `SFH_UNDERRUN_BYTE;
          end
          SFH_DIN: begin
            // Status data is kept for the deselect; program data streams out.
            d.have_wdata = 1'b1;
            d.wdata = in_byte;
            if (q.opcode != `SFH_OP_STATUS_WRITE) begin
              d.wr_strobe = 1'b1;
              d.wr_byte = in_byte;
            end
          end
          SFH_DOUT: begin
            // Next output byte is loaded ahead of its first falling edge.
            if (q.opcode == `SFH_OP_STATUS_READ) begin
              d.out_sh = status_now;
            end else begin
              buf_pop = buf_valid;
              d.out_sh = buf_valid ? buf_data : `SFH_UNDERRUN_BYTE;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sck_fall && q.out_act) begin
      // Output bits change after the falling edge, most significant first.
      d.sdo = q.out_sh[7];
      d.out_sh = {q.out_sh[6:0], 1'b0};
      d.sdo_oe = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with power-up values of the status fields.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.phase <= SFH_OPC;
      q.sck_prev <= 1'b0;
      q.sel_prev <= 1'b1;
      q.write_latch <= 1'b0;
      q.guard <= `SFH_GUARD_RESET;
      q.guard_lockdown <= `SFH_LOCK_RESET;
      q.sdo <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Status word register so the observation port comes from a flop.
  logic [7:0] state_word_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_word_q <= {`SFH_LOCK_RESET, 1'b0, `SFH_GUARD_RESET, 2'b00};
    end else begin
      state_word_q <= status_now;
    end
  end

  // Outputs straight from the state register and the status word register.
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;
  assign op_strobe = q.op_strobe;
  assign op_code = q.op_code;
  assign op_addr = q.op_addr;
  assign erase_span = q.erase_span;
  assign wr_strobe = q.wr_strobe;
  assign wr_byte = q.wr_byte;
  assign flash_state_word = state_word_q;

endmodule

// ==== sim/sfh_front_sva.sv ====
// Port checker for the flash front end, bound below to the design.
// Assumes one ref_clk domain whose synchronous reset is srst.
`timescale 1ns/100ps
module sfh_front_sva import sfh_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Serial pins.
  input wire logic sel_n,
  input wire logic sck,
  input wire logic pause_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  // Engine side.
  input wire logic busy_in,
  input wire logic streaming_program_flag,
  input wire logic ready_busy_en,
  input wire logic op_strobe,
  input wire logic [7:0] op_code,
  input wire logic [16:0] erase_span,
  input wire logic wr_strobe,
  input wire logic [7:0] flash_state_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Ready/busy display owns the output pin, so it is kept out of the float checks.
  wire rb_mode = streaming_program_flag && ready_busy_en;
  sequence s_paused;
    (!pause_n && !sck && !rb_mode)[*8];
  endsequence
  sequence s_idle_rb;
    (sel_n && rb_mode && $stable(busy_in))[*8];
  endsequence
  a_busy_bit: assert property ($stable(busy_in)[*3] |-> flash_state_word[0] == busy_in)
    else $error("busy bit does not follow the engine");
  a_stream_bit: assert property ($rose(streaming_program_flag) |-> ##[1:3] flash_state_word[6])
    else $error("streaming flag not shown in the status word");
  a_strobe_sel: assert property (op_strobe |-> sel_n && !$past(op_strobe))
    else $error("operation request not a single pulse after deselect");
  a_span_code: assert property (op_strobe |-> erase_span == (op_code == 8'h20 ? 17'h01000 :
    op_code == 8'h52 ? 17'h08000 : op_code == 8'hd8 ? 17'h10000 : 17'h00000))
    else $error("erase span does not match the opcode");
  a_code_hold: assert property (!op_strobe |-> $stable(op_code) && $stable(erase_span))
    else $error("request fields moved without a strobe");
  a_wr_pulse: assert property (wr_strobe |-> !sel_n ##1 !wr_strobe)
    else $error("program data pulse outside a frame or too long");
  a_oe_release: assert property ($rose(sel_n) && !rb_mode |-> ##[1:8] !sdo_oe)
    else $error("output still driven after deselect");
  a_pause_float: assert property (s_paused |-> !sdo_oe)
    else $error("output driven while paused");
  a_rb_show: assert property (s_idle_rb |-> sdo_oe && sdo == !busy_in)
    else $error("ready busy level wrong on the output");
endmodule
bind sfh_flash_front sfh_front_sva u_sva (.ref_clk(ref_clk), .srst(srst), .sel_n(sel_n), .sck(sck),
  .pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe), .busy_in(busy_in),
  .streaming_program_flag(streaming_program_flag), .ready_busy_en(ready_busy_en), .op_strobe(op_strobe),
  .op_code(op_code), .erase_span(erase_span), .wr_strobe(wr_strobe), .flash_state_word(flash_state_word));

// ==== sim/sfh_host_model.sv ====
// Host controller model: frames, shifts and pauses on the serial pins.
// Assumes the caller sets cpol while deselected; clock is a 125 ns link clock.
`timescale 1ns/100ps
module sfh_host_model import sfh_pkg::*; (
  // Driven toward the device.
  output logic sel_n,
  output logic sck,
  output logic sdi,
  output logic pause_n,
  // Returned by the device.
  input wire logic sdo,
  input wire logic sdo_oe
);
  localparam realtime HALF = 62.5;
  logic cpol = 1'b0;
  // A released output is read as unknown so it never passes for data.
  wire logic so = sdo_oe ? sdo : 1'bx;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    pause_n = 1'b1;
  end
  //////////////////////////////////////////
  // Clock parks at its idle level before select moves.
  task automatic sel(input logic lvl);
    sck = cpol;
    #(HALF);
    sel_n = lvl;
    #(HALF);
  endtask
  // Data changes with the clock low and is read back at the rise.
  task automatic shift(input logic [7:0] tx, input int n, inout logic [7:0] rx);
    repeat (n) begin
      sck = 1'b0;
      sdi = tx[7];
      tx = {tx[6:0], 1'b0};
      #(HALF);
      sck = 1'b1;
      rx = {rx[6:0], so};
      #(HALF);
    end
    sck = cpol;
  endtask
  // Pause moves only with the clock low, inside a frame or after deselect.
  task automatic hold(input logic lvl);
    #(HALF);
    pause_n = lvl;
    #(HALF);
  endtask
  // Clock and data noise that a paused device must ignore.
  task automatic wiggle();
    repeat (3) begin
      sck = 1'b1;
      sdi = ~sdi;
      #(HALF);
      sck = 1'b0;
      #(HALF);
    end
  endtask
endmodule

// ==== sim/sfh_testbench.sv ====
// Self-checking bench: host model on the pins, engine stubs on the far side.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
module testbench import sfh_pkg::*;;
  logic ref_clk, srst, wprot_n, busy_in, stream, rb_en, op_done, rd_valid;
  logic [7:0] rd_data;
  wire logic sel_n, sck, sdi, pause_n;
  logic sdo, sdo_oe, op_strobe, wr_strobe, rd_ready;
  logic [7:0] op_code, wr_byte, flash_state_word, v, r;
  logic [23:0] op_addr;
  logic [16:0] erase_span;
  int errors, compares, n_op, n_wr, n0;
  logic [7:0] eop [4] = '{8'h20, 8'h52, 8'hd8, 8'h02};
  logic [16:0] esp [4] = '{17'h01000, 17'h08000, 17'h10000, 17'h00000};
  logic [7:0] rdx [3] = '{8'ha5, 8'h3c, 8'hff};
  always #5 ref_clk = ~ref_clk;
  sfh_host_model u_host (.sel_n(sel_n), .sck(sck), .sdi(sdi), .pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe));
  sfh_flash_front u_dut (.ref_clk(ref_clk), .srst(srst), .sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .pause_n(pause_n), .wprot_n(wprot_n), .busy_in(busy_in),
    .streaming_program_flag(stream), .ready_busy_en(rb_en), .op_done(op_done), .op_strobe(op_strobe),
    .op_code(op_code), .op_addr(op_addr), .erase_span(erase_span), .wr_strobe(wr_strobe),
    .wr_byte(wr_byte), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .flash_state_word(flash_state_word));
  // Count requests leaving toward the engine.
  always @(posedge ref_clk) begin
    if (op_strobe === 1'b1) n_op++;
    if (wr_strobe === 1'b1) n_wr++;
  end
  //////////////////////////////////////////
  // Engine-side inputs move one step after the edge.
  task automatic at();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic done(input string what);
    $display("test %s done", what);
  endtask
  // Whole frame: opcode, then n bytes of arg from the top; effects land at deselect.
  task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] arg);
    logic [7:0] rx;
    rx = 8'h00;
    u_host.sel(1'b0);
    u_host.shift(op, 8, rx);
    repeat (n) begin
      u_host.shift(arg[31:24], 8, rx);
      arg = arg << 8;
    end
    u_host.sel(1'b1);
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic rdst(output logic [7:0] st);
    logic [7:0] rx;
    rx = 8'h00;
    u_host.sel(1'b0);
    u_host.shift(8'h05, 8, rx);
    u_host.shift(8'h00, 8, rx);
    u_host.sel(1'b1);
    st = rx;
    at();
  endtask
  // Valid and data hold until ready is seen at an edge.
  task automatic push(input logic [7:0] d);
    at();
    rd_data = d;
    rd_valid = 1'b1;
    while (rd_ready !== 1'b1) at();
    at();
    rd_valid = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////
  // The whole run needs well under this span.
  initial begin
    #500us;
    errors++;
    report_and_stop();
  end
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    {wprot_n, busy_in, stream, rb_en, op_done, rd_valid, rd_data} = {1'b1, 5'h00, 8'h00};
    repeat (6) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    repeat (10) at();
    chk("reset word", 8'h1c, flash_state_word);
    for (int m = 1; m >= 0; m--) begin
      u_host.cpol = m[0];
      rdst(v);
      chk("status read", 8'h1c, v);
    end
    done("reset and modes");
    cmd(8'h06, 0, 0);
    chk("latch set", 1, flash_state_word[1]);
    cmd(8'h04, 0, 0);
    chk("latch clear", 0, flash_state_word[1]);
    cmd(8'h50, 0, 0);
    cmd(8'h01, 1, 32'hff000000);
    rdst(v);
    chk("status write", 8'hbc, v);
    wprot_n = 1'b0;
    cmd(8'h06, 0, 0);
    cmd(8'h01, 1, 32'h00000000);
    chk("locked write", 8'hbc, flash_state_word);
    wprot_n = 1'b1;
    cmd(8'h06, 0, 0);
    cmd(8'h01, 1, 32'h00000000);
    chk("unprotected write", 8'h00, flash_state_word);
    wprot_n = 1'b0;
    cmd(8'h06, 0, 0);
    cmd(8'h01, 1, 32'h10000000);
    chk("unlocked write", 8'h10, flash_state_word);
    wprot_n = 1'b1;
    done("status word");
    n0 = n_op;
    cmd(8'h20, 3, 32'h0a10005a);
    chk("unarmed erase", n0, n_op);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h06, 0, 0);
      cmd(eop[i], (i == 3) ? 4 : 3, 32'h0a10005a);
      chk("op count", n0 + i + 1, n_op);
      chk("op code", eop[i], op_code);
      chk("op addr", 24'h0a1000, op_addr);
      chk("erase span", esp[i], erase_span);
      at();
      op_done = 1'b1;
      at();
      op_done = 1'b0;
      repeat (3) at();
      chk("latch after op", 0, flash_state_word[1]);
    end
    chk("program data", 8'h5a, wr_byte);
    chk("program count", 1, n_wr);
    done("operations");
    busy_in = 1'b1;
    stream = 1'b1;
    rb_en = 1'b1;
    repeat (12) at();
    chk("busy stream bits", 2'b11, {flash_state_word[6], flash_state_word[0]});
    chk("busy on pin", 2'b10, {sdo_oe, sdo});
    rdst(v);
    chk("status while busy", 8'h51, v);
    repeat (12) at();
    busy_in = 1'b0;
    repeat (12) at();
    chk("ready on pin", 3'b011, {flash_state_word[0], sdo_oe, sdo});
    stream = 1'b0;
    rb_en = 1'b0;
    repeat (12) at();
    done("busy");
    r = 8'h00;
    u_host.sel(1'b0);
    u_host.shift(8'h05, 8, r);
    u_host.shift(8'h00, 4, r);
    u_host.hold(1'b0);
    repeat (10) at();
    chk("paused float", 0, sdo_oe);
    u_host.wiggle();
    u_host.hold(1'b1);
    u_host.shift(8'h00, 4, r);
    u_host.sel(1'b1);
    chk("resumed byte", 8'h10, r);
    u_host.sel(1'b0);
    u_host.shift(8'h06, 8, r);
    u_host.hold(1'b0);
    u_host.sel(1'b1);
    repeat (10) at();
    chk("paused deselect", 0, sdo_oe);
    u_host.hold(1'b1);
    rdst(v);
    chk("no command kept", 8'h10, v);
    done("pause");
    push(8'ha5);
    push(8'h3c);
    repeat (2) at();
    chk("buffer full", 0, rd_ready);
    u_host.sel(1'b0);
    u_host.shift(8'h03, 8, r);
    repeat (3) u_host.shift(8'h00, 8, r);
    for (int k = 0; k < 3; k++) begin
      r = 8'h00;
      u_host.shift(8'h00, 8, r);
      chk("read byte", rdx[k], r);
    end
    u_host.sel(1'b1);
    repeat (4) at();
    chk("buffer drained", 1, rd_ready);
    done("read buffer");
    report_and_stop();
  end
endmodule
